// [core/etpc_axil.sv]
// axi4-lite slave front end: one write and one read at a time
// assumes the register file answers reads and write errors combinationally
`timescale 1ns/1ps
`default_nettype none
module etpc_axil
  import etpc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // read channels
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // register file side
  output etpc_wreq_t wreq,
  input wire logic wr_err,
  output logic [31:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_err
);
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [31:0] aw_q, wd_q, rdata_q;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  wire wr_fire;

  // both halves held and no answer pending
  assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
  assign wreq = '{en: wr_fire, addr: aw_q, data: wd_q, strb: ws_q};
  assign rd_addr = araddr;
  assign {awready, wready, bvalid, bresp} = {awready_q, wready_q, bvalid_q, bresp_q};
  assign {arready, rvalid, rdata, rresp} = {arready_q, rvalid_q, rdata_q, rresp_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awready_q, wready_q, arready_q} <= 3'h7;
      {bvalid_q, rvalid_q} <= 2'h0;
      {aw_q, wd_q, rdata_q} <= '0;
      {ws_q, bresp_q, rresp_q} <= '0;
    end else begin
      if (awvalid && awready_q) begin
        aw_q <= awaddr;
        awready_q <= 1'b0;
      end
      if (wvalid && wready_q) begin
        {wd_q, ws_q} <= {wdata, wstrb};
        wready_q <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_q && bready) begin
        {bvalid_q, awready_q, wready_q} <= 3'b011;
      end
      if (arvalid && arready_q) begin
        {arready_q, rvalid_q} <= 2'b01;
        rdata_q <= rd_data;
        rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
      end
      if (rvalid_q && rready) begin
        {rvalid_q, arready_q} <= 2'b01;
      end
    end
  end
endmodule
`default_nettype wire

// [core/etpc_chan.sv]
// one channel pin: output shaping in pwm modes, edge capture detection
// assumes pin_in is synchronous to aclk
`timescale 1ns/1ps
`default_nettype none
module etpc_chan
  import etpc_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // configuration
  input wire etpc_chan_cfg_t cfg,
  input wire logic pwm_mode,
  input wire logic cap_mode,
  input wire logic pin_unused,
  // raw generator level
  input wire logic active,
  // pin
  input wire logic pin_in,
  output logic pin_out,
  output logic pin_oe,
  // capture event
  output logic cap_stb
);
  logic pin_prev_q;
  logic pin_out_q;
  logic pin_oe_q;
  wire level;
  wire drive;
  wire rise;
  wire fall;
  wire drive_en;

  assign level = (cfg.out_ctrl ? active : ~active) ^ cfg.invert;
  // forced levels leave the generator running upstream
  assign drive = (cfg.pin_func == FUNC_LOW) ? 1'b0 :
                 (cfg.pin_func == FUNC_HIGH) ? 1'b1 : level;
  assign drive_en = pwm_mode & ~pin_unused;
  assign rise = pin_in & ~pin_prev_q;
  assign fall = ~pin_in & pin_prev_q;
  assign cap_stb = cap_mode & ((cfg.pin_func == CAP_RISE & rise) |
                   (cfg.pin_func == CAP_FALL & fall) |
                   (cfg.pin_func == CAP_BOTH & (rise | fall)));
  assign pin_out = pin_out_q;
  assign pin_oe = pin_oe_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_prev_q <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q <= 1'b0;
    end else begin
      pin_prev_q <= pin_in;
      pin_out_q <= drive_en & drive;
      pin_oe_q <= drive_en;
    end
  end
endmodule
`default_nettype wire

// [core/etpc_top.sv]
// enhanced timer: pwm output, single pulse output and capture input modes
// assumes pins and the external trigger are synchronous to aclk (10 mhz)
`timescale 1ns/1ps
`default_nettype none
module etpc_top
  import etpc_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [31:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // channel pins
  input wire logic chan_a_pin_in,
  output logic chan_a_pin_out,
  output logic chan_a_pin_oe,
  input wire logic chan_b_pin_in,
  output logic chan_b_pin_out,
  output logic chan_b_pin_oe,
  // external trigger
  input wire logic ext_clock_pin,
  // match flags
  output logic chan_a_match_flag,
  output logic chan_b_match_flag,
  output logic period_match_flag
);
  logic [7:0] ctrl_one_q, ctrl_two_q, period_q;
  logic [CNT_W-1:0] cmp_a_q, cmp_b_q, cnt_q;
  logic [2:0] flags_q;
  logic up_q, run_prev_q, ext_prev_q, pulse_b_q;
  logic [31:0] rd_data;
  logic rd_err;
  etpc_wreq_t wreq;

  function automatic logic hit(input logic [31:0] a, input logic [31:0] o);
    hit = (a == o);
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // configuration decode
  wire etpc_chan_cfg_t cfg_a = etpc_chan_cfg_t'(ctrl_one_q[5:0]);
  wire etpc_chan_cfg_t cfg_b = etpc_chan_cfg_t'(ctrl_two_q[5:0]);
  wire clr_src = ctrl_one_q[CF_CLR_SRC];
  wire run = ctrl_one_q[CF_RUN];
  wire etpc_align_t align = etpc_align_t'(ctrl_two_q[CF_ALIGN+1:CF_ALIGN]);
  // both channel mode pairs are expected equal; channel a's pair steers
  wire pwm_mode = cfg_a.mode_sel == ETPC_MODE_PWM;
  wire cap_mode = cfg_a.mode_sel == ETPC_MODE_CAP;
  wire spm = pwm_mode & (cfg_a.pin_func == FUNC_ONE);
  wire pwm_run = pwm_mode & ~spm;
  wire centre = pwm_run & (align != ALIGN_EDGE);
  wire a_sets_period = pwm_run & clr_src;
  wire run_rise = run & ~run_prev_q;
  wire ext_rise = ext_clock_pin & ~ext_prev_q;
  // the count is stale in the run rise cycle, so no match may fire then
  wire live = run & ~run_rise;

  // write decode
  wire wr_one = wreq.en & hit(wreq.addr, OFS_CTRL_ONE) & wreq.strb[0];
  wire wr_two = wreq.en & hit(wreq.addr, OFS_CTRL_TWO) & wreq.strb[0];
  wire wr_per = wreq.en & hit(wreq.addr, OFS_PERIOD) & wreq.strb[0];
  wire wr_cma = wreq.en & hit(wreq.addr, OFS_CMP_A);
  wire wr_cmb = wreq.en & hit(wreq.addr, OFS_CMP_B);
  wire wr_flg = wreq.en & hit(wreq.addr, OFS_FLAGS) & wreq.strb[0];
  wire wr_known = hit(wreq.addr, OFS_CTRL_ONE) | hit(wreq.addr, OFS_CTRL_TWO) |
                  hit(wreq.addr, OFS_PERIOD) | hit(wreq.addr, OFS_CMP_A) |
                  hit(wreq.addr, OFS_CMP_B) | hit(wreq.addr, OFS_FLAGS) |
                  hit(wreq.addr, OFS_COUNT);
  wire wr_err = ~wr_known;

  // period limits; period byte zero lets the edge counter use all 65536 states
  wire [15:0] top_p = (period_q == 8'h00) ? CNT_FULL :
                      16'({period_q, 8'h00} - 16'h0001);
  wire [15:0] top_e = a_sets_period ? 16'(cmp_a_q - 16'h0001) : top_p;
  wire [15:0] half = clr_src ? cmp_a_q :
                     (period_q == 8'h00) ? HALF_FULL :
                     {1'b0, period_q, 7'h00};
  wire [15:0] lim = centre ? 16'(half - 16'h0001) : top_e;
  wire at_top = cnt_q == top_e;
  wire [15:0] cnt_inc = 16'(cnt_q + 16'h0001);
  wire [15:0] cnt_dec = 16'(cnt_q - 16'h0001);
  wire turn_down = up_q & (cnt_inc == half);
  wire turn_up = ~up_q & (cnt_q == 16'h0001);

  // comparator matches
  wire eq_a = cnt_q == cmp_a_q;
  wire eq_b = cnt_q == cmp_b_q;
  wire dir_ok = (align == ALIGN_BOTH) | ((align == ALIGN_UP) & up_q) |
                ((align == ALIGN_DOWN) & ~up_q);
  wire match_a = live & (centre ? eq_a & dir_ok :
                 a_sets_period ? at_top : eq_a);
  wire match_b = live & eq_b & (~centre | dir_ok);
  wire match_p = live & ~spm &
                 (centre ? turn_up : at_top & ~a_sets_period);
  wire spm_end = spm & live & eq_a;

  // raw generator levels; duty at or beyond the period saturates
  wire duty_a = (cnt_q < cmp_a_q) | (cmp_a_q > lim);
  wire duty_b = (cnt_q < cmp_b_q) | (cmp_b_q > lim);
  wire act_a = spm ? run : run & duty_a;
  wire act_b = spm ? pulse_b_q & run : run & duty_b;

  wire cap_a;
  wire cap_b;
  wire [2:0] flag_set = {match_p,
                         match_b | (spm & live & eq_b) | cap_b,
                         match_a | spm_end | cap_a};

  // read decode
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    if (hit(araddr, OFS_CTRL_ONE)) begin
      rd_data = {24'h000000, ctrl_one_q};
    end else if (hit(araddr, OFS_CTRL_TWO)) begin
      rd_data = {24'h000000, ctrl_two_q};
    end else if (hit(araddr, OFS_PERIOD)) begin
      rd_data = {24'h000000, period_q};
    end else if (hit(araddr, OFS_CMP_A)) begin
      rd_data = {16'h0000, cmp_a_q};
    end else if (hit(araddr, OFS_CMP_B)) begin
      rd_data = {16'h0000, cmp_b_q};
    end else if (hit(araddr, OFS_FLAGS)) begin
      rd_data = {29'h00000000, flags_q};
    end else if (hit(araddr, OFS_COUNT)) begin
      rd_data = {16'h0000, cnt_q};
    end else begin
      rd_err = 1'b1;
    end
  end

  etpc_axil u_axil (
    .aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .wreq(wreq), .wr_err(wr_err),
    .rd_addr(), .rd_data(rd_data), .rd_err(rd_err)
  );

  // channel a pin idles when channel a sets the period
  etpc_chan u_chan_a (
    .aclk(aclk), .aresetn(aresetn), .cfg(cfg_a),
    .pwm_mode(pwm_mode), .cap_mode(cap_mode), .pin_unused(a_sets_period),
    .active(act_a), .pin_in(chan_a_pin_in), .pin_out(chan_a_pin_out),
    .pin_oe(chan_a_pin_oe), .cap_stb(cap_a)
  );

  etpc_chan u_chan_b (
    .aclk(aclk), .aresetn(aresetn), .cfg(cfg_b),
    .pwm_mode(pwm_mode), .cap_mode(cap_mode), .pin_unused(1'b0),
    .active(act_b), .pin_in(chan_b_pin_in), .pin_out(chan_b_pin_out),
    .pin_oe(chan_b_pin_oe), .cap_stb(cap_b)
  );

  // control registers; hardware trigger beats software, software beats
  // the automatic stop
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl_one_q, ctrl_two_q, period_q} <= {CTRL_RST, CTRL_RST, PERIOD_RST};
    end else begin
      if (spm_end) begin
        ctrl_one_q[CF_RUN] <= 1'b0;
      end
      if (wr_one) begin
        ctrl_one_q <= wreq.data[7:0];
      end
      if (spm & ext_rise) begin
        ctrl_one_q[CF_RUN] <= 1'b1;
      end
      if (wr_two) begin
        ctrl_two_q <= wreq.data[7:0];
      end
      if (wr_per) begin
        period_q <= wreq.data[7:0];
      end
    end
  end

  // channel registers; a capture beats a software write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {cmp_a_q, cmp_b_q} <= {CMP_RST, CMP_RST};
    end else begin
      cmp_a_q <= cap_a ? cnt_q : wr_cma ? merge16(cmp_a_q, wreq.data, wreq.strb) :
                 cmp_a_q;
      cmp_b_q <= cap_b ? cnt_q : wr_cmb ? merge16(cmp_b_q, wreq.data, wreq.strb) :
                 cmp_b_q;
    end
  end

  // sticky flags, write one to clear, a new event wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~(wr_flg ? wreq.data[2:0] : 3'h0)) | flag_set;
    end
  end
  assign chan_a_match_flag = flags_q[FL_A];
  assign chan_b_match_flag = flags_q[FL_B];
  assign period_match_flag = flags_q[FL_P];

  // counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
      {up_q, run_prev_q, ext_prev_q, pulse_b_q} <= 4'b1000;
    end else begin
      run_prev_q <= run;
      ext_prev_q <= ext_clock_pin;
      pulse_b_q <= spm & live & (pulse_b_q | eq_b);
      if (run_rise) begin
        cnt_q <= 16'h0000;
        up_q <= 1'b1;
      end else if (!run) begin
        cnt_q <= cnt_q;
      end else if (spm) begin
        cnt_q <= cnt_inc;
      end else if (centre) begin
        cnt_q <= up_q ? cnt_inc : cnt_dec;
        up_q <= turn_down ? 1'b0 : turn_up ? 1'b1 : up_q;
      end else begin
        cnt_q <= at_top ? 16'h0000 : cnt_inc;
      end
    end
  end

  default clocking dcb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_trigger;
    spm && ext_rise && !run && !wr_one;
  endsequence
  sequence s_restart;
    run ##1 (cnt_q == 16'h0000);
  endsequence

  edge_wrap_a: assert property (pwm_run && !centre && run && !run_rise &&
    at_top |=> cnt_q == 16'h0000) else $error("edge counter did not wrap");
  pulse_stop_a: assert property (spm_end && !wr_one && !ext_rise |=> !run)
    else $error("a match did not stop run");
  ext_start_a: assert property (s_trigger |=> s_restart)
    else $error("trigger did not start pulse");
  cap_latch_a: assert property (cap_a |=> cmp_a_q == $past(cnt_q) &&
    flags_q[FL_A]) else $error("capture a not latched");
  full_duty_a: assert property (pwm_run && run && cmp_b_q > lim |-> act_b)
    else $error("saturated duty not active");
  down_zero_a: assert property (centre && run && !run_rise && turn_up
    |=> flags_q[FL_P] && cnt_q == 16'h0000) else $error("no zero flag");
  force_high_a: assert property (pwm_mode && !a_sets_period &&
    cfg_a.pin_func == FUNC_HIGH |=> chan_a_pin_out)
    else $error("forced high not driven");
  centre_turn_a: assert property (centre && run && !run_rise && turn_down
    |=> !up_q ##1 $past(cnt_q) == half) else $error("peak missed");
  cap_off_a: assert property (cap_mode && cfg_a.pin_func == CAP_OFF |-> !cap_a)
    else $error("disabled capture fired");
  match_flag_a: assert property (match_a |=> flags_q[FL_A])
    else $error("match a flag lost");
endmodule
`default_nettype wire

// [inc/etpc_pkg.sv]
// shared constants and types of the enhanced timer pwm / capture block
// assumes a 32-bit axi4-lite register bus and a 16-bit counter
package etpc_pkg;
  // register byte offsets
  localparam logic [31:0] OFS_CTRL_ONE = 32'h0000_0000;
  localparam logic [31:0] OFS_CTRL_TWO = 32'h0000_0004;
  localparam logic [31:0] OFS_PERIOD = 32'h0000_0008;
  localparam logic [31:0] OFS_CMP_A = 32'h0000_000c;
  localparam logic [31:0] OFS_CMP_B = 32'h0000_0010;
  localparam logic [31:0] OFS_FLAGS = 32'h0000_0014;
  localparam logic [31:0] OFS_COUNT = 32'h0000_0018;
  // field positions
  localparam int CF_CLR_SRC = 6;
  localparam int CF_RUN = 7;
  localparam int CF_ALIGN = 6;
  localparam int FL_A = 0;
  localparam int FL_B = 1;
  localparam int FL_P = 2;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] PERIOD_RST = 8'h00;
  localparam logic [15:0] CMP_RST = 16'h0000;
  // counter limits
  localparam logic [15:0] CNT_FULL = 16'hffff;
  localparam logic [15:0] HALF_FULL = 16'h8000;
  // capture edge codes of the pin-function pair
  localparam logic [1:0] CAP_RISE = 2'b00;
  localparam logic [1:0] CAP_FALL = 2'b01;
  localparam logic [1:0] CAP_BOTH = 2'b10;
  localparam logic [1:0] CAP_OFF = 2'b11;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ETPC_MODE_CMP = 2'b00, ETPC_MODE_CAP = 2'b01,
    ETPC_MODE_PWM = 2'b10, ETPC_MODE_TMR = 2'b11
  } etpc_mode_t;
  typedef enum logic [1:0] {
    FUNC_LOW = 2'b00, FUNC_HIGH = 2'b01, FUNC_PWM = 2'b10, FUNC_ONE = 2'b11
  } etpc_func_t;
  typedef enum logic [1:0] {
    ALIGN_EDGE = 2'b00, ALIGN_UP = 2'b01, ALIGN_DOWN = 2'b10, ALIGN_BOTH = 2'b11
  } etpc_align_t;
  // low six bits of each control register
  typedef struct packed {
    logic invert;
    logic out_ctrl;
    etpc_func_t pin_func;
    etpc_mode_t mode_sel;
  } etpc_chan_cfg_t;
  typedef struct packed {
    logic en;
    logic [31:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } etpc_wreq_t;
endpackage

// [verif/etpc_pins_model.sv]
// far side of the timer: loads and sources on the two pins, trigger source
// assumes every bench request changes just after a rising edge of aclk
`timescale 1ns/1ps
`default_nettype none
module etpc_pins_model (
  // block side
  input wire logic aclk,
  input wire logic [1:0] oe,
  input wire logic [1:0] out,
  // bench requests
  input wire logic [1:0] src,
  input wire logic trig,
  // pin levels
  output logic [1:0] pin,
  output logic ext_pin
);
  // a source only reaches a pin that the block has released
  assign pin = (oe & out) | (~oe & src);
  // high for one cycle at a time, so a request held one or two cycles gives one rising edge
  always @(posedge aclk) begin
    ext_pin <= trig & ~ext_pin;
  end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
// self-checking bench of the timer: pwm, single pulse and capture modes
// assumes a 10 mhz aclk and pins synchronous to it
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import etpc_pkg::*;
;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig;
  logic awready, wready, bvalid, arready, rvalid, fa, fb, fp, ext_pin;
  logic [31:0] awaddr, wdata, araddr, rdata, rv, c1;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, src;
  wire [1:0] oe, out, pin;
  int error_cnt, comparisons, seed, cyc, ca, cb, wa, a, b;

  etpc_top #(.CNT_W(16)) DUT (.aclk(aclk), .aresetn(aresetn),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .chan_a_pin_in(pin[0]), .chan_a_pin_out(out[0]), .chan_a_pin_oe(oe[0]),
    .chan_b_pin_in(pin[1]), .chan_b_pin_out(out[1]), .chan_b_pin_oe(oe[1]),
    .ext_clock_pin(ext_pin), .chan_a_match_flag(fa),
    .chan_b_match_flag(fb), .period_match_flag(fp));
  etpc_pins_model PEER (.aclk(aclk), .oe(oe), .out(out), .src(src),
    .trig(trig), .pin(pin), .ext_pin(ext_pin));

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // a hang is cut short well beyond the few thousand cycles needed
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [31:0] ad, d);
    @(posedge aclk);
    awvalid <= 1'b1;
    awaddr <= ad;
    wvalid <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] ad);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr <= ad;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rv = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // counts high cycles seen on both pins over a window
  task automatic meas(input int n);
    ca = 0;
    cb = 0;
    repeat (n) begin
      @(posedge aclk);
      ca += (pin[0] === 1'b1);
      cb += (pin[1] === 1'b1);
    end
  endtask

  // run is first written low so the final write gives a clean run rise
  task automatic cfg(input logic [7:0] t1, t2, p, input logic [15:0] va, vb);
    wr(OFS_CTRL_ONE, {24'h0, t1 & 8'h7f});
    wr(OFS_CTRL_TWO, {24'h0, t2});
    wr(OFS_PERIOD, {24'h0, p});
    wr(OFS_CMP_A, {16'h0, va});
    wr(OFS_CMP_B, {16'h0, vb});
    wr(OFS_FLAGS, 32'h7);
    wr(OFS_CTRL_ONE, {24'h0, t1});
  endtask

  function automatic int edge_hi(input int duty, input int per);
    return (duty >= per) ? per : duty;
  endfunction

  function automatic int ctr_hi(input int duty);
    return 2 * duty - 1;
  endfunction

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, trig} = 7'h0;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    src = 2'b00;
    seed = 85987;
    {error_cnt, comparisons, cyc} = 0;
    idle(20);
    aresetn <= 1'b1;
    rd(OFS_COUNT);
    chk(rv, 32'h0, "count at reset");
    rd(32'h40);
    chk(rs, RESP_SLVERR, "unmapped read");
    wr(32'h40, 32'h0);
    chk(rs, RESP_SLVERR, "unmapped write");
    wr(OFS_CMP_A, 32'hffff);
    rd(OFS_CMP_A);
    chk(rv, 32'hffff, "sixteen bit compare");
    cfg(8'h9a, 8'h1a, 8'h01, 16'd64, 16'd300);
    idle(300);
    meas(256);
    chk(ca, edge_hi(64, 256), "edge duty a");
    chk(cb, edge_hi(300, 256), "full duty b");
    chk({fa, fp}, 2'b11, "a and period flags");
    for (int i = 0; i < 3; i++) begin
      a = (i == 1) ? 100 : 156;
      cfg((i == 1) ? 8'h92 : 8'h96, (i == 0) ? 8'h3a : {2'h0, i[0], 5'h0a},
        8'h01, 16'd64, 16'd100);
      idle(300);
      meas(256);
      chk(cb, a, "b polarity");
      chk(ca, (i == 1) ? 0 : 256, "a forced level");
      chk({fp, fb, fa}, 3'h7, "flags while forced");
    end
    repeat (3) begin
      a = 16 + ($random(seed) & 255);
      b = 1 + (($random(seed) & 32'hffff) % (a - 1));
      cfg(8'hda, 8'h1a, 8'h00, a[15:0], b[15:0]);
      idle(2 * a);
      meas(a);
      chk(cb, edge_hi(b, a), "period from a");
      chk(oe[0], 1'b0, "a pin released");
    end
    for (int m = 1; m < 4; m++) begin
      b = 1 + ($random(seed) & 63);
      cfg(8'h9a, {m[1:0], 6'h1a}, 8'h01, 16'd20, b[15:0]);
      idle(300);
      meas(256);
      chk(ca, ctr_hi(20), "centre a");
      chk(cb, ctr_hi(b), "centre b");
      chk(fp, 1'b1, "period flag on down count");
    end
    cfg(8'hda, 8'hda, 8'h00, 16'd50, 16'd10);
    idle(200);
    meas(100);
    chk(cb, ctr_hi(10), "centre period from a");
    cfg(8'h1e, 8'h1e, 8'h00, 16'd40, 16'd15);
    wr(OFS_CTRL_ONE, 32'h9e);
    meas(100);
    wa = ca;
    chk(ca >= 40 && ca <= 43, 1'b1, "a pulse from run rise");
    chk(ca - cb >= 15 && ca - cb <= 17, 1'b1, "b on b match");
    rd(OFS_CTRL_ONE);
    chk(rv[7], 1'b0, "run cleared by a match");
    chk({fb, fa}, 2'b11, "pulse flags");
    trig <= 1'b1;
    idle(1);
    trig <= 1'b0;
    meas(100);
    chk(ca, wa, "trigger restarts from zero");
    cfg(8'h1e, 8'h1e, 8'h00, 16'd400, 16'd15);
    wr(OFS_CTRL_ONE, 32'h9e);
    idle(50);
    wr(OFS_CTRL_ONE, 32'h1e);
    idle(2);
    meas(20);
    chk(ca + cb, 0, "software stop ends pulses");
    cfg(8'h81, 8'h0d, 8'h01, 16'h0, 16'h0);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_CTRL_ONE, 32'h81 | (k << 2));
      wr(OFS_FLAGS, 32'h7);
      rd(OFS_COUNT);
      c1 = rv;
      src <= 2'b11;
      idle(2);
      chk({fb, fa}, {1'b0, k == 0 || k == 2}, "rise capture");
      rd(OFS_CMP_A);
      if (k == 0) chk(8'(rv[7:0] - c1[7:0]) < 8'd16, 1'b1, "latched");
      wr(OFS_FLAGS, 32'h7);
      src <= 2'b00;
      idle(2);
      chk({fb, fa}, {1'b0, k == 1 || k == 2}, "fall capture");
    end
    wr(OFS_FLAGS, 32'h7);
    idle(300);
    chk(fp, 1'b1, "capture period wrap");
    rd(OFS_COUNT);
    chk(rv < 32'd256, 1'b1, "top byte compare");
    end_sim();
  end
endmodule
`default_nettype wire
